// ===== include/adcw_consts.vh
`ifndef ADCW_CONSTS_VH
`define ADCW_CONSTS_VH

// register indices; byte address is four times the index
`define ADCW_IDX_CTRLA 5'h00
`define ADCW_IDX_CTRLB 5'h01
`define ADCW_IDX_CTRLC 5'h02
`define ADCW_IDX_CTRLD 5'h03
`define ADCW_IDX_CTRLE 5'h04
`define ADCW_IDX_SAMPCTRL 5'h05
`define ADCW_IDX_CHANSEL 5'h06
`define ADCW_IDX_COMMAND 5'h08
`define ADCW_IDX_INTCTRL 5'h0a
`define ADCW_IDX_INTFLAGS 5'h0b
`define ADCW_IDX_RESULT 5'h10
`define ADCW_IDX_WIN_LOW 5'h12
`define ADCW_IDX_WIN_HIGH 5'h14

// field positions
`define ADCW_CTRLA_ENABLE 0
`define ADCW_CTRLA_FREERUN 1
`define ADCW_CTRLC_PRESC_LSB 0
`define ADCW_CTRLC_REF_LSB 4
`define ADCW_CTRLC_CAP 6
`define ADCW_CTRLD_SAMPDLY_LSB 0
`define ADCW_CTRLD_INIT_LSB 5
`define ADCW_INT_READY 0
`define ADCW_INT_WINDOW 1
`define ADCW_CMD_START 0

// reset values
`define ADCW_RST_BYTE 8'h00
`define ADCW_RST_WORD 16'h0000

// reference encodings
`define ADCW_REF_INTERNAL 2'h0
`define ADCW_REF_VDD 2'h1
`define ADCW_REF_EXTERNAL 2'h2

// window modes
`define ADCW_WIN_OFF 3'h0
`define ADCW_WIN_BELOW 3'h1
`define ADCW_WIN_ABOVE 3'h2
`define ADCW_WIN_INSIDE 3'h3
`define ADCW_WIN_OUTSIDE 3'h4

// timing in converter clock cycles; full-scale result code
`define ADCW_CONV_CYCLES 9'd13
`define ADCW_SAMPLE_START 9'd2
`define ADCW_INIT_UNIT 9'd16
`define ADCW_FULL_SCALE 10'h3ff

`endif

// ===== design/adcw_prescaler.v
`timescale 1ns/1ps
module adcw_prescaler #(
  parameter PW = 8
) (
  input wire clk_i,
  input wire resetn_i,
  input wire run_i,
  input wire [2:0] presc_i,
  output reg tick_o
);
  reg [PW-1:0] cnt_reg;
  wire [PW-1:0] last;

  // factor 2^(presc+1); at 256 the shift wraps to zero and last is all ones
  assign last = ({{(PW-1){1'b0}}, 1'b1} << ({1'b0, presc_i} + 4'd1))
                - {{(PW-1){1'b0}}, 1'b1};

  // held at zero while idle so the start delay is fixed
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_reg == last);
      if (cnt_reg == last)
        cnt_reg <= {PW{1'b0}};
      else
        cnt_reg <= cnt_reg + {{(PW-1){1'b0}}, 1'b1};
    end
  end
endmodule // adcw_prescaler

// ===== design/adcw_window_cmp.v
`timescale 1ns/1ps
`include "adcw_consts.vh"
module adcw_window_cmp #(
  parameter W = 16
) (
  input wire clk_i,
  input wire resetn_i,
  input wire valid_i,
  input wire [W-1:0] value_i,
  input wire [W-1:0] low_i,
  input wire [W-1:0] high_i,
  input wire [2:0] mode_i,
  output reg hit_o
);
  reg cond;

  always @* begin
    case (mode_i)
      `ADCW_WIN_BELOW: cond = (value_i < low_i);
      `ADCW_WIN_ABOVE: cond = (value_i > high_i);
      `ADCW_WIN_INSIDE: cond = (value_i > low_i) && (value_i < high_i);
      `ADCW_WIN_OUTSIDE: cond = (value_i < low_i) || (value_i > high_i);
      default: cond = 1'b0;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      hit_o <= 1'b0;
    else
      hit_o <= valid_i && cond;
  end
endmodule // adcw_window_cmp

// ===== design/adcw_top.v
`timescale 1ns/1ps
`include "adcw_consts.vh"
module adcw_top #(
  parameter TEMP_CHANNEL = 5'h1e,
  parameter PRESC_W = 8
) (
  input wire clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [9:0] analog_code_i,
  input wire over_ref_i,
  output reg [4:0] input_channel_select_o,
  output reg [1:0] reference_select_o,
  output reg temp_sensor_en_o,
  output reg sample_capacitor_select_o,
  output reg sample_hold_o,
  output reg busy_o,
  output reg result_irq_o,
  output reg window_irq_o
);
  reg [7:0] ctrla_reg;
  reg [7:0] ctrlb_reg;
  reg [7:0] ctrlc_reg;
  reg [7:0] ctrld_reg;
  reg [7:0] ctrle_reg;
  reg [7:0] sampctrl_reg;
  reg [4:0] chan_shadow_reg;
  reg [1:0] intctrl_reg;
  reg [15:0] win_low_reg;
  reg [15:0] win_high_reg;
  reg [15:0] result_reg;
  reg result_ready_flag_reg;
  reg window_compare_flag_reg;
  reg pending_reg;
  reg busy_reg;
  reg first_reg;
  reg [8:0] cnt_reg;
  reg [6:0] samp_reg;
  reg [15:0] acc_reg;
  reg done_reg;
  reg [4:0] act_chan_reg;
  reg [1:0] act_ref_reg;

  wire adc_tick;
  wire win_hit;
  wire enable = ctrla_reg[`ADCW_CTRLA_ENABLE];
  wire freerun = ctrla_reg[`ADCW_CTRLA_FREERUN];
  wire [1:0] ref_shadow = ctrlc_reg[`ADCW_CTRLC_REF_LSB +: 2];
  wire [3:0] sampdly = ctrld_reg[`ADCW_CTRLD_SAMPDLY_LSB +: 4];
  wire [2:0] initial_delay = ctrld_reg[`ADCW_CTRLD_INIT_LSB +: 3];
  wire [4:0] sample_length = sampctrl_reg[4:0];
  wire [2:0] window_mode_select = ctrle_reg[2:0];

  // apb decode; response comes one cycle into the access phase
  wire [4:0] idx = paddr_i[6:2];
  wire addr_ok = (paddr_i[31:7] == 25'h0) && (paddr_i[1:0] == 2'h0);
  wire access = psel_i && penable_i && !pready_o;
  wire commit = psel_i && penable_i && pready_o;
  wire wr = commit && pwrite_i;
  wire rd = commit && !pwrite_i;

  function mapped;
    input [4:0] i;
    begin
      case (i)
        `ADCW_IDX_CTRLA, `ADCW_IDX_CTRLB, `ADCW_IDX_CTRLC,
        `ADCW_IDX_CTRLD, `ADCW_IDX_CTRLE, `ADCW_IDX_SAMPCTRL,
        `ADCW_IDX_CHANSEL, `ADCW_IDX_COMMAND, `ADCW_IDX_INTCTRL,
        `ADCW_IDX_INTFLAGS, `ADCW_IDX_RESULT, `ADCW_IDX_WIN_LOW,
        `ADCW_IDX_WIN_HIGH: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function wr_hit;
    input [4:0] i;
    input [4:0] want;
    input ok;
    input w;
    begin
      wr_hit = w && ok && (i == want);
    end
  endfunction

  // sample count above 64 would overflow the 16-bit sum
  function [6:0] last_sample;
    input [2:0] n;
    begin
      if (n > 3'd6)
        last_sample = 7'h3f;
      else
        last_sample = (7'h01 << n) - 7'h01;
    end
  endfunction

  wire [8:0] init_extra = first_reg
                          ? (`ADCW_INIT_UNIT * {6'h0, initial_delay})
                          : 9'h000;
  wire [8:0] samp_end = `ADCW_SAMPLE_START + init_extra
                        + {5'h0, sampdly} + {4'h0, sample_length};
  wire [8:0] conv_len = `ADCW_CONV_CYCLES + init_extra
                        + {5'h0, sampdly} + {4'h0, sample_length};
  wire last_cycle = busy_reg && (cnt_reg == conv_len - 9'd1);
  wire last_samp = (samp_reg == last_sample(ctrlb_reg[2:0]));
  wire final_cycle = last_cycle && last_samp;
  wire [9:0] code = over_ref_i ? `ADCW_FULL_SCALE : analog_code_i;
  wire [15:0] acc_sum = acc_reg + {6'h00, code};
  wire start_wr = wr_hit(idx, `ADCW_IDX_COMMAND, addr_ok, wr)
                  && pwdata_i[`ADCW_CMD_START];
  wire rd_result = rd && addr_ok && (idx == `ADCW_IDX_RESULT);
  wire wr_flags = wr_hit(idx, `ADCW_IDX_INTFLAGS, addr_ok, wr);

  adcw_prescaler #(
    .PW(PRESC_W)
  ) u_presc (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .run_i(enable && (pending_reg || busy_reg)),
    .presc_i(ctrlc_reg[`ADCW_CTRLC_PRESC_LSB +: 3]),
    .tick_o(adc_tick)
  );

  adcw_window_cmp #(
    .W(16)
  ) u_win (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .valid_i(done_reg),
    .value_i(result_reg),
    .low_i(win_low_reg),
    .high_i(win_high_reg),
    .mode_i(window_mode_select),
    .hit_o(win_hit)
  );

  // register writes
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrla_reg <= `ADCW_RST_BYTE;
      ctrlb_reg <= `ADCW_RST_BYTE;
      ctrlc_reg <= `ADCW_RST_BYTE;
      ctrld_reg <= `ADCW_RST_BYTE;
      ctrle_reg <= `ADCW_RST_BYTE;
      sampctrl_reg <= `ADCW_RST_BYTE;
      chan_shadow_reg <= 5'h00;
      intctrl_reg <= 2'h0;
      win_low_reg <= `ADCW_RST_WORD;
      win_high_reg <= `ADCW_RST_WORD;
    end else if (wr && addr_ok) begin
      case (idx)
        `ADCW_IDX_CTRLA: ctrla_reg <= {5'h00, pwdata_i[2:0]};
        `ADCW_IDX_CTRLB: ctrlb_reg <= {5'h00, pwdata_i[2:0]};
        `ADCW_IDX_CTRLC: ctrlc_reg <= {1'b0, pwdata_i[6:4], 1'b0,
                                       pwdata_i[2:0]};
        `ADCW_IDX_CTRLD: ctrld_reg <= {pwdata_i[7:5], 1'b0,
                                       pwdata_i[3:0]};
        `ADCW_IDX_CTRLE: ctrle_reg <= {5'h00, pwdata_i[2:0]};
        `ADCW_IDX_SAMPCTRL: sampctrl_reg <= {3'h0, pwdata_i[4:0]};
        `ADCW_IDX_CHANSEL: chan_shadow_reg <= pwdata_i[4:0];
        `ADCW_IDX_INTCTRL: intctrl_reg <= pwdata_i[1:0];
        `ADCW_IDX_WIN_LOW: win_low_reg <= pwdata_i[15:0];
        `ADCW_IDX_WIN_HIGH: win_high_reg <= pwdata_i[15:0];
        default: ctrla_reg <= ctrla_reg;
      endcase
    end
  end

  // conversion sequencer
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_reg <= 1'b0;
      busy_reg <= 1'b0;
      first_reg <= 1'b0;
      cnt_reg <= 9'h000;
      samp_reg <= 7'h00;
      acc_reg <= `ADCW_RST_WORD;
      result_reg <= `ADCW_RST_WORD;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!enable) begin
        pending_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else begin
        if (start_wr && !busy_reg)
          pending_reg <= 1'b1;
        if (adc_tick) begin
          if (pending_reg && !busy_reg) begin
            // starts on the converter edge after the command
            pending_reg <= 1'b0;
            busy_reg <= 1'b1;
            first_reg <= 1'b1;
            cnt_reg <= 9'h000;
            samp_reg <= 7'h00;
            acc_reg <= `ADCW_RST_WORD;
          end else if (busy_reg) begin
            if (last_cycle) begin
              cnt_reg <= 9'h000;
              first_reg <= 1'b0;
              if (last_samp) begin
                result_reg <= acc_sum;
                done_reg <= 1'b1;
                samp_reg <= 7'h00;
                acc_reg <= `ADCW_RST_WORD;
                busy_reg <= freerun;
              end else begin
                samp_reg <= samp_reg + 7'h01;
                acc_reg <= acc_sum;
              end
            end else begin
              cnt_reg <= cnt_reg + 9'd1;
            end
          end
        end
      end
    end
  end

  // active selections follow shadows except mid-conversion
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_chan_reg <= 5'h00;
      act_ref_reg <= `ADCW_REF_INTERNAL;
    end else if (!busy_reg || final_cycle) begin
      act_chan_reg <= chan_shadow_reg;
      act_ref_reg <= ref_shadow;
    end
  end

  // flags: hardware set wins over software clear
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_ready_flag_reg <= 1'b0;
      window_compare_flag_reg <= 1'b0;
    end else begin
      if (done_reg)
        result_ready_flag_reg <= 1'b1;
      else if (rd_result || (wr_flags && pwdata_i[`ADCW_INT_READY]))
        result_ready_flag_reg <= 1'b0;
      if (win_hit)
        window_compare_flag_reg <= 1'b1;
      else if (wr_flags && pwdata_i[`ADCW_INT_WINDOW])
        window_compare_flag_reg <= 1'b0;
    end
  end

  // outputs
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_channel_select_o <= 5'h00;
      reference_select_o <= `ADCW_REF_INTERNAL;
      temp_sensor_en_o <= 1'b0;
      sample_capacitor_select_o <= 1'b0;
      sample_hold_o <= 1'b0;
      busy_o <= 1'b0;
      result_irq_o <= 1'b0;
      window_irq_o <= 1'b0;
    end else begin
      input_channel_select_o <= act_chan_reg;
      reference_select_o <= act_ref_reg;
      temp_sensor_en_o <= enable
                          && (act_chan_reg == TEMP_CHANNEL);
      sample_capacitor_select_o <= ctrlc_reg[`ADCW_CTRLC_CAP];
      sample_hold_o <= busy_reg && (cnt_reg < samp_end);
      busy_o <= pending_reg || busy_reg;
      result_irq_o <= result_ready_flag_reg && intctrl_reg[`ADCW_INT_READY];
      window_irq_o <= window_compare_flag_reg
                      && intctrl_reg[`ADCW_INT_WINDOW];
    end
  end

  // apb response
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= access;
      pslverr_o <= access && !(addr_ok && mapped(idx));
      if (access && !pwrite_i && addr_ok) begin
        case (idx)
          `ADCW_IDX_CTRLA: prdata_o <= {24'h0, ctrla_reg};
          `ADCW_IDX_CTRLB: prdata_o <= {24'h0, ctrlb_reg};
          `ADCW_IDX_CTRLC: prdata_o <= {24'h0, ctrlc_reg};
          `ADCW_IDX_CTRLD: prdata_o <= {24'h0, ctrld_reg};
          `ADCW_IDX_CTRLE: prdata_o <= {24'h0, ctrle_reg};
          `ADCW_IDX_SAMPCTRL: prdata_o <= {24'h0, sampctrl_reg};
          `ADCW_IDX_CHANSEL: prdata_o <= {27'h0, chan_shadow_reg};
          `ADCW_IDX_COMMAND: prdata_o <= {31'h0, pending_reg || busy_reg};
          `ADCW_IDX_INTCTRL: prdata_o <= {30'h0, intctrl_reg};
          `ADCW_IDX_INTFLAGS: prdata_o <= {30'h0, window_compare_flag_reg,
                                           result_ready_flag_reg};
          `ADCW_IDX_RESULT: prdata_o <= {16'h0, result_reg};
          `ADCW_IDX_WIN_LOW: prdata_o <= {16'h0, win_low_reg};
          `ADCW_IDX_WIN_HIGH: prdata_o <= {16'h0, win_high_reg};
          default: prdata_o <= 32'h00000000;
        endcase
      end else if (access) begin
        prdata_o <= 32'h00000000;
      end
    end
  end
endmodule // adcw_top

// ===== tb/adcw_properties.sv
`timescale 1ns/1ps
module adcw_properties #(
  parameter TEMP_CHANNEL = 5'h1e
) (
  input wire clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire pready_o,
  input wire [4:0] input_channel_select_o,
  input wire [1:0] reference_select_o,
  input wire temp_sensor_en_o,
  input wire sample_hold_o,
  input wire busy_o,
  input wire result_irq_o,
  input wire window_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_ready_timing:
    assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("ready late");
  a_ready_in_access:
    assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_sel_frozen:
    assert property (sample_hold_o && $past(sample_hold_o) |->
      $stable(input_channel_select_o) && $stable(reference_select_o))
    else $error("selection moved while sampling");
  a_hold_in_busy:
    assert property (sample_hold_o |-> busy_o)
    else $error("sampling while idle");
  a_start_to_sample:
    assert property ($rose(busy_o) |-> ##[1:600] sample_hold_o)
    else $error("conversion never sampled");
  a_temp_sensor_on:
    assert property (temp_sensor_en_o |-> input_channel_select_o ==
      TEMP_CHANNEL || $past(input_channel_select_o) == TEMP_CHANNEL)
    else $error("sensor on for other channel");
  a_idle_copy_cause:
    assert property ($changed(input_channel_select_o) |-> $past(busy_o)
      || $past(pwrite_i) || $past(pwrite_i, 2))
    else $error("channel changed without cause");
  a_win_irq_clear:
    assert property ($fell(window_irq_o) |-> $past(pwrite_i)
      || $past(pwrite_i, 2) || $past(pwrite_i, 3))
    else $error("window irq dropped unasked");
  a_result_irq_clear:
    assert property ($fell(result_irq_o) |-> $past(pready_o)
      || $past(pready_o, 2) || $past(pready_o, 3))
    else $error("result irq dropped unasked");
endmodule // adcw_properties

// ===== tb/adcw_analog_model.sv
`timescale 1ns/1ps
module adcw_analog_model (
  input wire clk_i,
  input wire [4:0] channel_i,
  input wire [1:0] ref_i,
  input wire hold_i,
  output reg [9:0] code_o,
  output reg over_ref_o
);
  // level tracks channel and reference; held between samples like a cap
  initial code_o = 10'h000;
  initial over_ref_o = 1'b0;
  always @(posedge clk_i) begin
    if (hold_i) begin
      code_o <= {ref_i, 3'h0, channel_i};
      over_ref_o <= (channel_i == 5'h1f);
    end
  end
endmodule // adcw_analog_model

// ===== tb/adcw_top_bench.sv
`timescale 1ns/1ps
module adcw_top_bench;
  localparam [4:0] TEMP_CH = 5'h1e;
  localparam [4:0] R_CTRLA = 5'h00, R_CTRLB = 5'h01, R_CTRLC = 5'h02;
  localparam [4:0] R_CTRLD = 5'h03, R_CTRLE = 5'h04, R_SAMP = 5'h05;
  localparam [4:0] R_CHAN = 5'h06, R_CMD = 5'h08, R_IEN = 5'h0a;
  localparam [4:0] R_FLAG = 5'h0b, R_RSLT = 5'h10, R_WLO = 5'h12;
  localparam [4:0] R_WHI = 5'h14;
  // mode, low, high, expected hit
  function [23:0] wtab(input integer k);
    begin
      case (k)
        0: wtab = 24'h0141e0;
        1: wtab = 24'h10a1e0;
        2: wtab = 24'h10b1e1;
        3: wtab = 24'h2050a0;
        4: wtab = 24'h205091;
        5: wtab = 24'h3090b1;
        6: wtab = 24'h30a0b0;
        7: wtab = 24'h4090b0;
        default: wtab = 24'h40b141;
      endcase
    end
  endfunction
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [31:0] paddr_i = 32'h0;
  reg [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, over_ref, temp_en, cap_sel, hold, busy;
  wire res_irq, win_irq;
  wire [9:0] code;
  wire [4:0] chan;
  wire [1:0] reference_select;
  integer errors = 0;
  integer num_checks = 0;
  integer i;
  reg [31:0] rd;
  reg [23:0] wt;
  reg err;

  adcw_top #(.TEMP_CHANNEL(TEMP_CH)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .analog_code_i(code), .over_ref_i(over_ref),
    .input_channel_select_o(chan), .reference_select_o(reference_select),
    .temp_sensor_en_o(temp_en), .sample_capacitor_select_o(cap_sel),
    .sample_hold_o(hold), .busy_o(busy), .result_irq_o(res_irq),
    .window_irq_o(win_irq));

  adcw_analog_model src_u (.clk_i(clk_i), .channel_i(chan),
    .ref_i(reference_select), .hold_i(hold), .code_o(code), .over_ref_o(over_ref));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("FAIL %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input w, input [4:0] idx, input [31:0] wd);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {25'h0, idx, 2'h0};
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // only the watchdog ends a transfer that is never answered
      do begin
        @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask

  task wr(input [4:0] idx, input [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task rc(input [4:0] idx, input [31:0] e, input string nm);
    begin
      apb(1'b0, idx, 32'h0);
      chk(nm, e, rd);
    end
  endtask

  // first cycles skipped so busy can rise; a hang is left to the watchdog
  task wait_done;
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (n < 3 || busy !== 1'b0);
      repeat (4) @(posedge clk_i);
    end
  endtask

  task conv;
    begin
      wr(R_CMD, 32'h1);
      wait_done;
    end
  endtask

  // skip cycles first so a flag just cleared is not taken as new
  task wait_res;
    begin
      repeat (3) @(posedge clk_i);
      while (res_irq !== 1'b1)
        @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    errors = errors + 1;
    summarize;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rc(R_CTRLC, 32'h0, "ctrlc reset");
    rc(R_CHAN, 32'h0, "channel reset");
    rc(R_WLO, 32'h0, "low reset");
    rc(R_WHI, 32'h0, "high reset");
    apb(1'b0, 5'h07, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(R_CTRLA, 32'h1);
    wr(R_CHAN, 32'h5);
    for (i = 0; i < 3; i = i + 1) begin
      wr(R_CTRLC, i << 4);
      conv;
      chk("reference", i, {30'h0, reference_select});
      rc(R_FLAG, 32'h1, "ready flag");
      rc(R_RSLT, {22'h0, i[1:0], 8'h05}, "result");
      rc(R_FLAG, 32'h0, "flag after read");
    end
    wr(R_CMD, 32'h1);
    wr(R_CHAN, 32'h6);
    wr(R_CTRLC, 32'h10);
    chk("frozen channel", 32'h5, {27'h0, chan});
    wait_done;
    chk("copied channel", 32'h6, {27'h0, chan});
    chk("copied ref", 32'h1, {30'h0, reference_select});
    rc(R_RSLT, 32'h205, "frozen result");
    wr(R_CHAN, 32'h1f);
    conv;
    rc(R_RSLT, 32'h3ff, "full scale");
    wr(R_CTRLC, 32'h47);
    wr(R_CTRLD, 32'h20);
    wr(R_SAMP, 32'h3);
    wr(R_CHAN, {27'h0, TEMP_CH});
    conv;
    chk("temp sensor", 32'h1, {31'h0, temp_en});
    chk("capacitor", 32'h1, {31'h0, cap_sel});
    rc(R_RSLT, {27'h0, TEMP_CH}, "temp result");
    wr(R_CTRLC, 32'h0);
    wr(R_CTRLD, 32'h0);
    wr(R_SAMP, 32'h0);
    wr(R_CHAN, 32'ha);
    for (i = 0; i < 9; i = i + 1) begin
      wt = wtab(i);
      wr(R_WLO, {24'h0, wt[19:12]});
      wr(R_WHI, {24'h0, wt[11:4]});
      wr(R_CTRLE, {29'h0, wt[22:20]});
      wr(R_IEN, {30'h0, i[0], 1'b0});
      conv;
      chk("window irq", {31'h0, wt[0] & i[0]}, {31'h0, win_irq});
      chk("result irq", 32'h0, {31'h0, res_irq});
      rc(R_FLAG, {30'h0, wt[0], 1'b1}, "window flag");
      wr(R_FLAG, 32'h3);
    end
    wr(R_CTRLB, 32'h2);
    wr(R_WLO, 32'h0);
    wr(R_WHI, 32'h1e);
    wr(R_CTRLE, 32'h2);
    conv;
    rc(R_FLAG, 32'h3, "sum flag");
    rc(R_RSLT, 32'h28, "sum");
    wr(R_FLAG, 32'h3);
    wr(R_CTRLB, 32'h0);
    wr(R_CTRLE, 32'h0);
    wr(R_IEN, 32'h1);
    wr(R_CHAN, 32'h3);
    wr(R_CTRLA, 32'h3);
    wr(R_CMD, 32'h1);
    wait_res;
    wr(R_CHAN, 32'h4);
    rc(R_RSLT, 32'h3, "first free");
    wait_res;
    rc(R_RSLT, 32'h3, "running free");
    wait_res;
    rc(R_RSLT, 32'h4, "new channel");
    wr(R_CTRLA, 32'h1);
    wait_done;
    summarize;
  end
endmodule // adcw_top_bench

bind adcw_top adcw_properties #(.TEMP_CHANNEL(TEMP_CHANNEL)) prop_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
  .input_channel_select_o(input_channel_select_o),
  .reference_select_o(reference_select_o),
  .temp_sensor_en_o(temp_sensor_en_o), .sample_hold_o(sample_hold_o),
  .busy_o(busy_o), .result_irq_o(result_irq_o),
  .window_irq_o(window_irq_o));
